// file: core/sac_params.svh
// Register offsets, field positions, reset values and timing counts of the converter control.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SAC_OFS_CTRL_A 2'h0
`define SAC_OFS_CTRL_B 2'h1
`define SAC_OFS_RES_HI 2'h2
`define SAC_OFS_RES_LO 2'h3

// ----------------------------------------------------------------
// Control A fields
// ----------------------------------------------------------------
`define SAC_A_START 0
`define SAC_A_REFSW 1
`define SAC_A_BUSY 2
`define SAC_A_DONE 3
`define SAC_A_CHAN_LSB 4

// ----------------------------------------------------------------
// Control B fields
// ----------------------------------------------------------------
`define SAC_B_CKSEL_LSB 0
`define SAC_B_CONT 2
`define SAC_B_IRQEN 3
`define SAC_B_HWSRC 4
`define SAC_B_TIM_LSB 5
`define SAC_B_PREC8 7

// ----------------------------------------------------------------
// Reset values, timing counts and interrupt number
// ----------------------------------------------------------------
`define SAC_RST_CTRL_A 8'h00
`define SAC_RST_CTRL_B 8'h00
`define SAC_COMPARE_STEPS 4'hA
`define SAC_IRQ_NUMBER 5'h12

`endif

// file: core/sac_pkg.sv
// Types shared by the converter control files.
package sac_pkg;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_bus_req_t;

  typedef struct packed {
    logic [3:0] channel;
    logic sample;
    logic compare;
    logic [3:0] bit_index;
    logic ref_on;
  } sac_analog_ctl_t;

  typedef enum logic [3:0] {
    SAC_IDLE = 4'b0001,
    SAC_START = 4'b0010,
    SAC_SAMPLE = 4'b0100,
    SAC_COMPARE = 4'b1000
  } sac_state_t;

endpackage

// file: core/sac_clkdiv.sv
// Conversion clock tick generator with a selectable divide ratio.
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_clkdiv (
  clk,
  rst_n,
  sel,
  sync_clr,
  tick
);
  input wire logic clk;
  input wire logic rst_n;
  input wire logic [1:0] sel;
  input wire logic sync_clr;
  output logic tick;

  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [3:0] limit;

  // Ratios of 1, 2, 4 and 8 machine clocks per conversion clock.
  assign limit = (sel == 2'h0) ? 4'h0 : (sel == 2'h1) ? 4'h1 : (sel == 2'h2) ? 4'h3 : 4'h7;
  assign tick = (cnt_reg == limit);
  assign cnt_next = (sync_clr || tick) ? 4'h0 : cnt_reg + 4'h1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// file: core/sac_edge_sync.sv
// Two-stage synchroniser with a rising edge detector for the hardware start.
`timescale 1ns/1ps
module sac_edge_sync (
  clk,
  rst_n,
  din,
  rise
);
  input wire logic clk;
  input wire logic rst_n;
  input wire logic din;
  output logic rise;

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  assign rise = s2_reg && !s3_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
endmodule

// file: core/sac_ctrl.sv
// Successive-approximation converter control with registers and conversion sequencer.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_ctrl (
  clk,
  rst_n,
  bus_req,
  rdata,
  stop_mode,
  watch_mode,
  timer_output_trigger,
  cmp_decision,
  analog_ctl,
  irq,
  irq_number
);
  import sac_pkg::*;

  input wire logic clk;
  input wire logic rst_n;
  input wire sac_pkg::sac_bus_req_t bus_req;
  output logic [7:0] rdata;
  input wire logic stop_mode;
  input wire logic watch_mode;
  input wire logic timer_output_trigger;
  input wire logic cmp_decision;
  output sac_pkg::sac_analog_ctl_t analog_ctl;
  output logic irq;
  output logic [4:0] irq_number;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [3:0] channel_reg;
  logic reference_switch_control_reg;
  logic completion_flag_reg;
  logic conversion_busy_flag_reg;
  logic [7:0] conv_control_reg_b;
  logic [1:0] result_upper_reg;
  logic [7:0] result_lower_reg;
  logic [7:0] rdata_reg;
  logic [9:0] sar_reg;
  logic [9:0] sar_next;
  sac_state_t state_reg;
  sac_state_t state_next;
  logic [3:0] step_reg;
  logic [3:0] step_next;
  logic [1:0] startup_reg;
  logic [1:0] startup_next;
  logic [7:0] res_lo_sel;
  logic [1:0] res_hi_sel;
  logic sample_reg;
  logic compare_reg;
  logic [3:0] bit_index_reg;
  genvar gi;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Each decode used in several places lives in one function, so the copies cannot disagree.
  function automatic logic addr_hit(
    input logic [1:0] addr,
    input logic [1:0] ofs
  );
    return (addr == ofs);
  endfunction

  function automatic logic state_is(
    input sac_state_t cur,
    input sac_state_t want
  );
    return (cur == want);
  endfunction

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  wire hit_a = addr_hit(bus_req.addr, `SAC_OFS_CTRL_A);
  wire hit_b = addr_hit(bus_req.addr, `SAC_OFS_CTRL_B);
  wire hit_hi = addr_hit(bus_req.addr, `SAC_OFS_RES_HI);
  wire in_compare = state_is(state_reg, SAC_COMPARE);
  wire wr_a = bus_req.wr && hit_a;
  wire wr_b = bus_req.wr && hit_b;
  wire wr_done_clear = wr_a && !bus_req.wdata[`SAC_A_DONE];
  wire [3:0] wr_channel = bus_req.wdata[`SAC_A_CHAN_LSB+:4];
  wire wr_refsw = bus_req.wdata[`SAC_A_REFSW];
  wire abort = stop_mode || watch_mode;
  wire continuous_trigger_enable = conv_control_reg_b[`SAC_B_CONT];
  wire hw_start_source_select = conv_control_reg_b[`SAC_B_HWSRC];
  wire precision_select = conv_control_reg_b[`SAC_B_PREC8];
  wire completion_irq_enable = conv_control_reg_b[`SAC_B_IRQEN];
  wire [1:0] sampling_time = conv_control_reg_b[`SAC_B_TIM_LSB+:2];
  wire [1:0] conv_clock_select = conv_control_reg_b[`SAC_B_CKSEL_LSB+:2];
  wire sw_start = wr_a && bus_req.wdata[`SAC_A_START];
  wire hw_edge;
  // A hardware start needs both the continuous enable and the timer source; either alone does nothing.
  wire hw_start = continuous_trigger_enable && hw_start_source_select && hw_edge;
  wire start_req = (sw_start || hw_start) && !abort;
  wire ck_tick;
  wire [3:0] sample_len = {2'h0, sampling_time} + 4'h1;
  wire [3:0] last_step = precision_select ? 4'h7 : 4'h9;
  wire compare_done = in_compare && (step_reg == `SAC_COMPARE_STEPS);
  wire startup_met = (startup_reg != 2'h0);
  wire sample_last = ck_tick && ((step_reg + 4'h1) == sample_len);
  wire compare_bit = ck_tick && (step_reg <= last_step);
  wire finish = compare_done && !abort;

  // Hardware edges pass through a synchroniser before they may start anything.
  sac_edge_sync u_edge (
    .clk(clk),
    .rst_n(rst_n),
    .din(timer_output_trigger),
    .rise(hw_edge)
  );

  // The divider restarts at a start request so phases line up with the conversion clock.
  sac_clkdiv u_div (
    .clk(clk),
    .rst_n(rst_n),
    .sel(conv_clock_select),
    .sync_clr(start_req),
    .tick(ck_tick)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    startup_next = startup_reg;
    sar_next = sar_reg;
    if (abort) begin
      state_next = SAC_IDLE;
    end else if (start_req) begin
      state_next = SAC_START;
      startup_next = 2'h0;
      step_next = 4'h0;
      sar_next = 10'h000;
    end else begin
      unique case (state_reg)
        SAC_IDLE: begin
          state_next = SAC_IDLE;
        end
        SAC_START: begin
          // At least two machine clocks, then leave on the next conversion clock.
          if (startup_reg != 2'h2) begin
            startup_next = startup_reg + 2'h1;
          end
          if (startup_met && ck_tick) begin
            state_next = SAC_SAMPLE;
            step_next = 4'h0;
          end
        end
        SAC_SAMPLE: begin
          if (ck_tick) begin
            step_next = step_reg + 4'h1;
            if (sample_last) begin
              state_next = SAC_COMPARE;
              step_next = 4'h0;
            end
          end
        end
        SAC_COMPARE: begin
          // Ten conversion clocks, with decisions on all ten or on the first eight at 8-bit precision, then one machine clock to transfer.
          if (step_reg == `SAC_COMPARE_STEPS) begin
            state_next = SAC_IDLE;
          end else if (ck_tick) begin
            if (compare_bit) begin
              sar_next[4'h9 - step_reg] = cmp_decision;
            end
            step_next = step_reg + 4'h1;
          end
        end
        default: begin
          state_next = SAC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= SAC_IDLE;
      step_reg <= 4'h0;
      startup_reg <= 2'h0;
      sar_reg <= 10'h000;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      startup_reg <= startup_next;
      sar_reg <= sar_next;
    end
  end

  // ----------------------------------------------------------------
  // Flags and results
  // ----------------------------------------------------------------
  // Abort outranks a start in the same cycle, so stop mode never leaves the busy flag set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conversion_busy_flag_reg <= 1'b0;
    end else if (abort) begin
      conversion_busy_flag_reg <= 1'b0;
    end else if (start_req) begin
      conversion_busy_flag_reg <= 1'b1;
    end else if (finish) begin
      conversion_busy_flag_reg <= 1'b0;
    end
  end

  // Set wins over a clear written in the same cycle, so no completion is lost.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      completion_flag_reg <= 1'b0;
    end else if (finish) begin
      completion_flag_reg <= 1'b1;
    end else if (wr_done_clear) begin
      completion_flag_reg <= 1'b0;
    end
  end

  // Results only change on a finished conversion; 8-bit results sit in the low byte.
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_res_lo
      assign res_lo_sel[gi] = precision_select ? sar_reg[gi + 2] : sar_reg[gi];
    end
  endgenerate
  assign res_hi_sel = precision_select ? 2'h0 : sar_reg[9:8];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_upper_reg <= 2'h0;
      result_lower_reg <= 8'h00;
    end else if (finish) begin
      result_upper_reg <= res_hi_sel;
      result_lower_reg <= res_lo_sel;
    end
  end

  // Channel changes mid-conversion are not blocked; software is expected to avoid them.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_reg <= 4'h0;
      reference_switch_control_reg <= 1'b0;
      conv_control_reg_b <= `SAC_RST_CTRL_B;
    end else begin
      if (wr_a) begin
        channel_reg <= wr_channel;
        reference_switch_control_reg <= wr_refsw;
      end
      if (wr_b) begin
        conv_control_reg_b <= bus_req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port and outputs
  // ----------------------------------------------------------------
  // The start bit always reads zero; it is a strobe, not a state.
  wire [7:0] ctrl_a_view = {
    channel_reg,
    completion_flag_reg,
    conversion_busy_flag_reg,
    reference_switch_control_reg,
    1'b0
  };
  wire [7:0] rd_mux = hit_a ? ctrl_a_view :
                      hit_b ? conv_control_reg_b :
                      hit_hi ? {6'h00, result_upper_reg} :
                      result_lower_reg;

  // Cycles without a read return zero, so a stale value is never mistaken for fresh data.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (bus_req.rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;
  assign irq = completion_flag_reg && completion_irq_enable;
  assign irq_number = `SAC_IRQ_NUMBER;

  // ----------------------------------------------------------------
  // Analog interface
  // ----------------------------------------------------------------
  // The controls come straight from flip-flops so the switches never see a decode glitch.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_reg <= 1'b0;
      compare_reg <= 1'b0;
      bit_index_reg <= 4'h9;
    end else begin
      sample_reg <= state_is(state_next, SAC_SAMPLE);
      compare_reg <= state_is(state_next, SAC_COMPARE);
      bit_index_reg <= 4'h9 - step_next;
    end
  end

  assign analog_ctl.channel = channel_reg;
  assign analog_ctl.sample = sample_reg;
  assign analog_ctl.compare = compare_reg;
  assign analog_ctl.bit_index = bit_index_reg;
  assign analog_ctl.ref_on = reference_switch_control_reg;
endmodule

// file: sim/sac_ctrl_properties.sv
// Port-level assertions for the converter control.
`timescale 1ns/1ps
module sac_ctrl_properties
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire sac_pkg::sac_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic stop_mode,
  input wire logic watch_mode,
  input wire logic timer_output_trigger,
  input wire logic cmp_decision,
  input wire sac_pkg::sac_analog_ctl_t analog_ctl,
  input wire logic irq,
  input wire logic [4:0] irq_number
);
  logic [7:0] cmp_len_reg;
  wire a0_wr = bus_req.wr && (bus_req.addr == 2'h0);
  wire go_wr = a0_wr && bus_req.wdata[0] && !stop_mode && !watch_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts compare cycles so the phase length can be judged when it ends.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cmp_len_reg <= 8'h00;
    else cmp_len_reg <= analog_ctl.compare ? cmp_len_reg + 8'h01 : 8'h00;
  end
  AST_IRQ_NUM: assert property (irq_number == 5'h12) else $error("bad irq number");
  AST_ABORT: assert property ((stop_mode || watch_mode) |=> !analog_ctl.sample && !analog_ctl.compare)
    else $error("no abort");
  AST_START: assert property (go_wr |=> !analog_ctl.sample ##1 !analog_ctl.sample ##[1:12] analog_ctl.sample)
    else $error("bad startup");
  AST_ORDER: assert property ($rose(analog_ctl.compare) |-> $past(analog_ctl.sample))
    else $error("compare without sample");
  AST_CMP_LEN: assert property ($fell(analog_ctl.compare) && !$past(stop_mode) && !$past(watch_mode)
    && !$past(bus_req.wr) |-> cmp_len_reg >= 8'h0B) else $error("compare too short");
  AST_IRQ_CLR: assert property (a0_wr && !bus_req.wdata[3] && !analog_ctl.compare |=> !irq)
    else $error("irq not cleared");
  AST_IRQ_HOLD: assert property (irq && !bus_req.wr |=> irq) else $error("irq dropped");
  AST_REF: assert property (a0_wr |=> analog_ctl.ref_on == $past(bus_req.wdata[1]))
    else $error("bad reference switch");
  AST_CHAN: assert property (a0_wr |=> analog_ctl.channel == $past(bus_req.wdata[7:4]))
    else $error("bad channel");
  cover property ($fell(analog_ctl.compare));
  cover property (irq);
  cover property (stop_mode && analog_ctl.compare);
endmodule

// file: sim/sac_analog_model.sv
// Behavioural sample-and-hold and comparator behind the converter control.
`timescale 1ns/1ps
module sac_analog_model
  import sac_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire sac_pkg::sac_analog_ctl_t analog_ctl,
  input wire logic [7:0][9:0] levels,
  output logic cmp_decision
);
  logic [9:0] held_reg;
  logic idle_reg;
  // Outside compare the line toggles so a stale decision is never read as valid.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) idle_reg <= 1'b0;
    else idle_reg <= ~idle_reg;
  end
  always_ff @(posedge clk) begin
    if (analog_ctl.sample) held_reg <= levels[analog_ctl.channel[2:0]];
  end
  assign cmp_decision = analog_ctl.compare ? held_reg[analog_ctl.bit_index] : idle_reg;
endmodule

// file: sim/sac_ctrl_tb.sv
// Self-checking bench for the converter control.
`timescale 1ns/1ps
module sac_ctrl_tb;
  import sac_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sac_bus_req_t bus_req = '0;
  logic stop_mode = 1'b0;
  logic watch_mode = 1'b0;
  logic timer_output_trigger = 1'b0;
  logic [7:0][9:0] levels = '0;
  logic [7:0] rdata;
  logic cmp_decision;
  logic irq;
  logic [4:0] irq_number;
  sac_analog_ctl_t analog_ctl;
  integer seed = 74250;
  int n_fail = 0;
  int checks_done = 0;
  logic [7:0] v;
  logic [7:0] hi;
  logic [7:0] b;
  logic [15:0] prev = '0;
  logic [2:0] ch;
  always #2.5 clk = ~clk;
  sac_ctrl sac_ctrl_inst (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata), .stop_mode(stop_mode),
    .watch_mode(watch_mode), .timer_output_trigger(timer_output_trigger), .cmp_decision(cmp_decision),
    .analog_ctl(analog_ctl), .irq(irq), .irq_number(irq_number));
  sac_analog_model sac_analog_model_inst (.clk(clk), .rst_n(rst_n), .analog_ctl(analog_ctl), .levels(levels),
    .cmp_decision(cmp_decision));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [1:0] a);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  function automatic logic [15:0] expect_res(input logic [9:0] lv, input logic p8);
    return p8 ? {8'h00, lv[9:2]} : {6'h00, lv};
  endfunction
  task automatic run_one();
    int k;
    wr(2'h1, b & 8'hFB);
    wr(2'h0, {1'b0, ch, 4'h3});
    rd(2'h0);
    check(v[2], 1'b1);
    rd(2'h2);
    hi = v;
    rd(2'h3);
    check({hi, v}, prev);
    k = 0;
    do begin
      rd(2'h0);
      k++;
    end while (v[3] !== 1'b1 && k < 200);
    check(v[3:2], 2'b10);
    check(irq, b[3]);
    rd(2'h2);
    hi = v;
    rd(2'h3);
    prev = expect_res(levels[ch], b[7]);
    check({hi, v}, prev);
    wr(2'h0, {1'b0, ch, 4'h0});
    check(irq, 1'b0);
    check(analog_ctl.ref_on, 1'b0);
  endtask
  initial begin
    #250000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(2'h0);
    check(v, 8'h00);
    #1 check(rdata, 8'h00);
    check(irq_number, 5'h12);
    for (int i = 0; i < 16; i++) begin
      ch = 3'($random(seed));
      levels[ch] = 10'($random(seed));
      b = 8'($random(seed));
      run_one();
    end
    wr(2'h2, 8'hFF);
    rd(2'h2);
    check(v, prev[15:8]);
    for (int m = 0; m < 2; m++) begin
      wr(2'h1, 8'h03);
      wr(2'h0, 8'h03);
      for (int k = 0; k < 300 && analog_ctl.compare !== 1'b1; k++) @(posedge clk);
      stop_mode <= (m == 0);
      watch_mode <= (m == 1);
      @(posedge clk);
      stop_mode <= 1'b0;
      watch_mode <= 1'b0;
      @(posedge clk);
      rd(2'h0);
      check(v[3:2], 2'b00);
    end
    for (int m = 0; m < 3; m++) begin
      wr(2'h0, 8'h00);
      wr(2'h1, {3'b000, m != 1, 1'b0, m != 2, 2'b00});
      timer_output_trigger <= 1'b1;
      repeat (2) @(posedge clk);
      timer_output_trigger <= 1'b0;
      repeat (5) @(posedge clk);
      rd(2'h0);
      check(v[2], 1'(m == 0));
      repeat (40) @(posedge clk);
    end
    conclude();
  end
endmodule
bind sac_ctrl sac_ctrl_properties sac_ctrl_properties_inst (.clk(clk), .rst_n(rst_n), .bus_req(bus_req),
  .rdata(rdata), .stop_mode(stop_mode), .watch_mode(watch_mode), .timer_output_trigger(timer_output_trigger),
  .cmp_decision(cmp_decision), .analog_ctl(analog_ctl), .irq(irq), .irq_number(irq_number));
